// ==== qlo_core.sv ====
// Quad LO divider and per-channel phase select with an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Each channel has its own phase shift, sixteen steps of 22.5 degrees.
// - Four-bit code, bit 0 least significant, means code times 22.5 degrees.
// - Equal codes give equal phase; one code higher leads by one step.
// - Quadrature LO phases come from dividing the quad-rate LO by four.
// - Both quadrature outputs have 50 percent duty whatever the LO shape.
// - Final I and Q flops are clocked by mclk_in, which samples the quad-rate LO edge.
// - Divider sync reset forces the divider to a known state.
// - LO interface and sync reset work only while a channel is enabled.
// - Serial control clear sets every control bit to zero.
module qlo_core
  import qlo_pkg::*;
#(
  parameter int unsigned NUM_CH = QLO_NUM_CH_DEF
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // LO and control pins
  input wire logic quad_rate_lo_input_pos_in,
  input wire logic quad_rate_lo_input_neg_in,
  input wire logic lo_divider_sync_reset_in,
  input wire logic serial_control_clear_in,
  // Divider and channel outputs
  output logic lo_i_out,
  output logic lo_q_out,
  output logic [NUM_CH-1:0] ch_enable_out,
  output logic [NUM_CH*QLO_CODE_W-1:0] ch_phase_out
);
  localparam int unsigned CW = NUM_CH * QLO_CODE_W;

  if (NUM_CH < 1 || CW > 32) begin : g_bad_num_ch
    $error("qlo_core: NUM_CH must give between 1 and 32 code bits");
  end

  // Phase words add the quadrant as the two top code bits, which needs four-bit codes
  if (QLO_CODE_W != 4) begin : g_bad_code_w
    $error("qlo_core: phase arithmetic needs four-bit codes");
  end

  // The decoded address bits must reach above the byte lanes of a word
  if (QLO_ADDR_W < 3) begin : g_bad_addr_w
    $error("qlo_core: too few decoded address bits");
  end

  // Registers are whole words, so every offset must be aligned and distinct
  if ((QLO_OFS_PHASE[1:0] != 2'b00) || (QLO_OFS_ENABLE[1:0] != 2'b00) ||
      (QLO_OFS_STATUS[1:0] != 2'b00) || (QLO_OFS_ACTIVE[1:0] != 2'b00)) begin : g_bad_ofs_align
    $error("qlo_core: register offsets must be word aligned");
  end

  if ((QLO_OFS_PHASE == QLO_OFS_ENABLE) || (QLO_OFS_PHASE == QLO_OFS_STATUS) ||
      (QLO_OFS_PHASE == QLO_OFS_ACTIVE) || (QLO_OFS_ENABLE == QLO_OFS_STATUS) ||
      (QLO_OFS_ENABLE == QLO_OFS_ACTIVE) || (QLO_OFS_STATUS == QLO_OFS_ACTIVE)) begin : g_bad_ofs_dup
    $error("qlo_core: register offsets must differ");
  end

  // Status fields must sit inside one word without overlapping
  if ((QLO_STAT_I_BIT <= QLO_STAT_RUN_BIT) || (QLO_STAT_Q_BIT <= QLO_STAT_I_BIT) ||
      (QLO_STAT_QUAD_LSB <= QLO_STAT_Q_BIT) || (QLO_STAT_PEND_BIT < QLO_STAT_QUAD_LSB + 2) ||
      (QLO_STAT_PEND_BIT > 31)) begin : g_bad_stat
    $error("qlo_core: status fields overlap or leave the word");
  end

  typedef struct packed {
    logic wr_pend;
    logic [QLO_ADDR_W-1:0] wr_addr;
    logic apply_pend;
    logic [CW-1:0] codes_stage;
    logic [CW-1:0] codes;
    logic [NUM_CH-1:0] enables;
    logic [CW-1:0] phase_words;
    logic lo_i;
    logic lo_q;
    logic [31:0] hrdata;
  } qlo_core_state_t;

  qlo_core_state_t st_reg;
  qlo_core_state_t st_next;
  logic addr_take;
  logic [31:0] rd_word;
  logic lo_run;

  qlo_div_if dif ();

  qlo_divider u_divider (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .dif(dif)
  );

  // Channel phase is the divider quadrant in 90 degree units plus the code in 22.5 degree units
  function automatic logic [QLO_CODE_W-1:0] phase_word(input logic [1:0] quad,
                                                       input logic [QLO_CODE_W-1:0] code);
    phase_word = {quad, 2'b00} + code;
  endfunction : phase_word

  function automatic logic [31:0] zext(input logic [CW-1:0] v);
    zext = QLO_RESET_WORD;
    zext[CW-1:0] = v;
  endfunction : zext

  // Only single word transfers are served; anything else is ignored with an OKAY response
  function automatic logic word_xfer(input logic sel, input logic rdy, input logic [1:0] trans,
                                     input logic [2:0] size);
    word_xfer = sel && rdy && (trans == QLO_HTRANS_NONSEQ) && (size == QLO_HSIZE_WORD);
  endfunction : word_xfer

  function automatic logic [31:0] status_word(input logic en_any, input logic i_lvl, input logic q_lvl,
                                              input logic [1:0] quad, input logic pend);
    status_word = QLO_RESET_WORD;
    status_word[QLO_STAT_RUN_BIT] = en_any;
    status_word[QLO_STAT_I_BIT] = i_lvl;
    status_word[QLO_STAT_Q_BIT] = q_lvl;
    status_word[QLO_STAT_QUAD_LSB +: 2] = quad;
    status_word[QLO_STAT_PEND_BIT] = pend;
  endfunction : status_word

  // Every channel adds its code to the shared quadrant, so equal codes give equal words
  function automatic logic [CW-1:0] phase_words_of(input logic [1:0] quad, input logic [CW-1:0] codes);
    phase_words_of = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      phase_words_of[c*QLO_CODE_W +: QLO_CODE_W] = phase_word(quad, codes[c*QLO_CODE_W +: QLO_CODE_W]);
    end
  endfunction : phase_words_of

  // With every channel off the LO interface idles and sync reset is ignored
  assign lo_run = |st_reg.enables;
  assign dif.lo_pos = quad_rate_lo_input_pos_in;
  assign dif.lo_neg = quad_rate_lo_input_neg_in;
  assign dif.run = lo_run;
  assign dif.sync_rst = lo_divider_sync_reset_in;

  assign addr_take = word_xfer(hsel_in, hready_in, htrans_in, hsize_in);

  // Read data is chosen in the address phase and stands for the data phase only
  always_comb begin
    rd_word = QLO_RESET_WORD;
    case (haddr_in[QLO_ADDR_W-1:0])
      QLO_OFS_PHASE: rd_word = zext(st_reg.codes_stage);
      QLO_OFS_ENABLE: rd_word[NUM_CH-1:0] = st_reg.enables;
      QLO_OFS_STATUS: rd_word = status_word(lo_run, dif.lo_i, dif.lo_q, dif.quadrant, st_reg.apply_pend);
      QLO_OFS_ACTIVE: rd_word = zext(st_reg.codes);
      default: rd_word = QLO_RESET_WORD;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.wr_pend = addr_take && hwrite_in;
    st_next.wr_addr = haddr_in[QLO_ADDR_W-1:0];
    st_next.hrdata = (addr_take && !hwrite_in) ? rd_word : QLO_RESET_WORD;
    st_next.apply_pend = 1'b0;
    // Whole word is present only in the data phase, so codes move one cycle later
    if (st_reg.apply_pend) begin
      st_next.codes = st_reg.codes_stage;
    end
    if (st_reg.wr_pend) begin
      case (st_reg.wr_addr)
        QLO_OFS_PHASE: begin
          st_next.codes_stage = hwdata_in[CW-1:0];
          st_next.apply_pend = 1'b1;
        end
        QLO_OFS_ENABLE: st_next.enables = hwdata_in[NUM_CH-1:0];
        default: st_next.wr_pend = st_next.wr_pend;
      endcase
    end
    // Clear beats any write in the same cycle
    if (serial_control_clear_in) begin
      st_next.codes_stage = '0;
      st_next.codes = '0;
      st_next.enables = '0;
      st_next.apply_pend = 1'b0;
    end
    st_next.phase_words = phase_words_of(dif.quadrant, st_reg.codes);
    st_next.lo_i = dif.lo_i;
    st_next.lo_q = dif.lo_q;
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= '0;
      st_reg.lo_i <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Zero wait states and only OKAY responses
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end

  assign hrdata_out = st_reg.hrdata;
  assign lo_i_out = st_reg.lo_i;
  assign lo_q_out = st_reg.lo_q;
  assign ch_enable_out = st_reg.enables;
  assign ch_phase_out = st_reg.phase_words;
endmodule : qlo_core
`default_nettype wire

// ==== qlo_core_checker.sv ====
// Port checks for the quad LO core
`timescale 1ns/1ps
`default_nettype none
module qlo_core_checker
  import qlo_pkg::*;
#(
  parameter int unsigned NUM_CH = QLO_NUM_CH_DEF
) (
  // Clock, reset and bus
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  // Control pins
  input wire logic lo_divider_sync_reset_in,
  input wire logic serial_control_clear_in,
  // Outputs
  input wire logic lo_i_out,
  input wire logic lo_q_out,
  input wire logic [NUM_CH-1:0] ch_enable_out,
  input wire logic [NUM_CH*QLO_CODE_W-1:0] ch_phase_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  logic all_eq;
  assign all_eq = ch_phase_out == {NUM_CH{ch_phase_out[QLO_CODE_W-1:0]}};
  property p_clr_en; serial_control_clear_in |=> ch_enable_out == '0; endproperty
  a_clr_en: assert property (p_clr_en) else $error("enables kept");
  property p_clr_eq; serial_control_clear_in |-> ##2 all_eq; endproperty
  a_clr_eq: assert property (p_clr_eq) else $error("phases differ");
  property p_sync; lo_divider_sync_reset_in && |ch_enable_out |-> ##2 (lo_i_out && !lo_q_out); endproperty
  a_sync: assert property (p_sync) else $error("sync lost");
  // Pins lag the divider, so only a long idle stretch proves it frozen
  property p_frozen; (ch_enable_out == '0) [*4] |-> $stable({lo_i_out, lo_q_out}); endproperty
  a_frozen: assert property (p_frozen) else $error("LO moved");
  property p_gray; $changed(lo_i_out) && $changed(lo_q_out) |-> $past(lo_divider_sync_reset_in, 2); endproperty
  a_gray: assert property (p_gray) else $error("double step");
  property p_qrise; $rose(lo_q_out) |-> lo_i_out; endproperty
  a_qrise: assert property (p_qrise) else $error("Q order");
  property p_ifall; $fell(lo_i_out) |-> lo_q_out; endproperty
  a_ifall: assert property (p_ifall) else $error("I order");
  property p_en_cause;
    $changed(ch_enable_out) |-> $past(serial_control_clear_in)
      || $past(hsel_in && hwrite_in && htrans_in == QLO_HTRANS_NONSEQ, 2);
  endproperty
  a_en_cause: assert property (p_en_cause) else $error("stray enable");
endmodule : qlo_core_checker
bind qlo_core qlo_core_checker #(.NUM_CH(NUM_CH)) u_chk (
  .mclk_in(mclk_in),
  .nrst_in(nrst_in),
  .hsel_in(hsel_in),
  .htrans_in(htrans_in),
  .hwrite_in(hwrite_in),
  .lo_divider_sync_reset_in(lo_divider_sync_reset_in),
  .serial_control_clear_in(serial_control_clear_in),
  .lo_i_out(lo_i_out),
  .lo_q_out(lo_q_out),
  .ch_enable_out(ch_enable_out),
  .ch_phase_out(ch_phase_out)
);
`default_nettype wire

// ==== qlo_core_tb_top.sv ====
// Self-checking bench for the quad LO core
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; $display("CHECK FAILED t=%0t %h %h", $time, a, b); end end
module qlo_core_tb_top;
  import qlo_pkg::*;
  logic mclk_in = 0, nrst_in = 0, hsel_in = 0, hwrite_in = 0, run = 0;
  logic lo_divider_sync_reset_in = 0, serial_control_clear_in = 0;
  logic [31:0] haddr_in = '0, hwdata_in = '0, hrdata_out;
  logic [1:0] htrans_in = '0;
  logic [2:0] hsize_in = '0;
  logic hreadyout_out, hresp_out, lo_p, lo_n, lo_i_out, lo_q_out;
  logic [3:0] ch_enable_out;
  logic [15:0] ch_phase_out, dw, pv;
  int checks = 0, fails = 0, q = 0;
  always #4 mclk_in = ~mclk_in;
  qlo_lo_src u_lo (.mclk_in(mclk_in), .run_in(run), .lo_pos_out(lo_p), .lo_neg_out(lo_n));
  qlo_core #(.NUM_CH(4)) u_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .quad_rate_lo_input_pos_in(lo_p), .quad_rate_lo_input_neg_in(lo_n),
    .lo_divider_sync_reset_in(lo_divider_sync_reset_in), .serial_control_clear_in(serial_control_clear_in),
    .lo_i_out(lo_i_out), .lo_q_out(lo_q_out), .ch_enable_out(ch_enable_out), .ch_phase_out(ch_phase_out));
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] wd, input logic [31:0] exp);
    @(posedge mclk_in);
    hsel_in <= 1;
    haddr_in <= {28'h000_0000, a};
    htrans_in <= QLO_HTRANS_NONSEQ;
    hwrite_in <= w;
    hsize_in <= QLO_HSIZE_WORD;
    do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
    hsel_in <= 0;
    htrans_in <= 2'b00;
    hwdata_in <= wd;
    do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
    if (!w) `CHK(hrdata_out, exp)
    `CHK(hresp_out, 1'b0)
  endtask : xfer
  task automatic step();
    run <= 1;
    repeat (4) @(posedge mclk_in);
    run <= 0;
    repeat (4) @(posedge mclk_in);
  endtask : step
  function automatic logic [31:0] stat(input int qq, input logic r);
    stat = {26'h0, 2'(qq), 1'b0, qq == 1 || qq == 2, qq < 2, r};
  endfunction : stat
  function automatic logic [15:0] sh(input logic [15:0] c, input int qq);
    for (int i = 0; i < 4; i++) sh[4*i+:4] = c[4*i+:4] + 4'(4 * qq);
  endfunction : sh
  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  initial begin
    #100000;
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge mclk_in);
    nrst_in <= 1;
    xfer(0, QLO_OFS_STATUS, 0, stat(0, 0));
    lo_divider_sync_reset_in <= 1;
    step();
    lo_divider_sync_reset_in <= 0;
    xfer(0, QLO_OFS_STATUS, 0, stat(0, 0));
    xfer(1, QLO_OFS_ENABLE, 32'h0000_000F, 0);
    for (int k = 0; k < 6; k++) begin
      step();
      q = (q + 1) % 4;
      xfer(0, QLO_OFS_STATUS, 0, stat(q, 1));
    end
    lo_divider_sync_reset_in <= 1;
    @(posedge mclk_in);
    lo_divider_sync_reset_in <= 0;
    repeat (3) @(posedge mclk_in);
    q = 0;
    `CHK({lo_i_out, lo_q_out}, 2'b10)
    pv = 16'h0000;
    for (int k = 0; k < 16; k += 4) begin
      dw = {4'(k + 3), 4'(k + 2), 4'(k + 1), 4'(k)};
      xfer(1, QLO_OFS_PHASE, {16'h0000, dw}, 0);
      @(posedge mclk_in);
      `CHK(ch_phase_out, pv)
      repeat (2) @(posedge mclk_in);
      pv = sh(dw, q);
      `CHK(ch_phase_out, pv)
      xfer(0, QLO_OFS_ACTIVE, 0, {16'h0000, dw});
    end
    step();
    q = 1;
    `CHK(ch_phase_out, sh(dw, q))
    serial_control_clear_in <= 1;
    @(posedge mclk_in);
    serial_control_clear_in <= 0;
    repeat (3) @(posedge mclk_in);
    `CHK(ch_enable_out, 4'h0)
    `CHK(ch_phase_out, sh(16'h0000, q))
    xfer(0, QLO_OFS_PHASE, 0, 0);
    step();
    xfer(0, QLO_OFS_STATUS, 0, stat(q, 0));
    report_and_stop();
  end
endmodule : qlo_core_tb_top
`default_nettype wire

// ==== qlo_div_if.sv ====
// Carrier between the register core and the LO divider
`timescale 1ns/1ps
`default_nettype none
interface qlo_div_if;
  logic lo_pos;
  logic lo_neg;
  logic run;
  logic sync_rst;
  logic [1:0] quadrant;
  logic lo_i;
  logic lo_q;
  modport core (output lo_pos, output lo_neg, output run, output sync_rst,
                input quadrant, input lo_i, input lo_q);
  modport div (input lo_pos, input lo_neg, input run, input sync_rst,
               output quadrant, output lo_i, output lo_q);
endinterface : qlo_div_if
`default_nettype wire

// ==== qlo_divider.sv ====
// Divide-by-four quadrature LO generator clocked by mclk_in, stepping on quad-rate LO rising edges
`timescale 1ns/1ps
`default_nettype none
module qlo_divider
  import qlo_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // Divider link
  qlo_div_if.div dif
);
  typedef struct packed {
    logic lo_prev;
    logic [1:0] quadrant;
    logic lo_i;
    logic lo_q;
  } qlo_div_state_t;

  qlo_div_state_t st_reg;
  qlo_div_state_t st_next;
  logic lo_level;
  logic lo_rise;

  // Only rising edges advance the count, so the high time of the LO is irrelevant
  assign lo_level = dif.lo_pos & ~dif.lo_neg;
  assign lo_rise = lo_level & ~st_reg.lo_prev;

  always_comb begin
    st_next = st_reg;
    st_next.lo_prev = lo_level;
    if (dif.run && dif.sync_rst) begin
      st_next.quadrant = QLO_QUAD_RESET;
      st_next.lo_i = 1'b1;
      st_next.lo_q = 1'b0;
    end else if (dif.run && lo_rise) begin
      st_next.quadrant = st_reg.quadrant + 2'd1;
      // Outputs toggle on LO edges only: each level lasts two edges
      st_next.lo_i = ~st_next.quadrant[1];
      st_next.lo_q = st_next.quadrant[1] ^ st_next.quadrant[0];
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= '{lo_prev: 1'b0, quadrant: QLO_QUAD_RESET, lo_i: 1'b1, lo_q: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign dif.quadrant = st_reg.quadrant;
  assign dif.lo_i = st_reg.lo_i;
  assign dif.lo_q = st_reg.lo_q;
endmodule : qlo_divider
`default_nettype wire

// ==== qlo_lo_src.sv ====
// Quad-rate LO source model, synchronous to the system clock
`timescale 1ns/1ps
`default_nettype none
module qlo_lo_src (
  // Clock and control
  input wire logic mclk_in,
  input wire logic run_in,
  // LO pair
  output logic lo_pos_out,
  output logic lo_neg_out
);
  logic [1:0] cnt_reg;
  always_ff @(posedge mclk_in) begin
    cnt_reg <= run_in ? cnt_reg + 2'h1 : 2'h0;
  end
  // One-in-four high time: the divider must make its own even duty
  assign lo_pos_out = run_in && (cnt_reg == 2'h1);
  assign lo_neg_out = !lo_pos_out;
endmodule : qlo_lo_src
`default_nettype wire

// ==== qlo_pkg.sv ====
// Shared constants for the quad LO divider and phase select block
package qlo_pkg;
  localparam int unsigned QLO_CODE_W = 4;
  localparam int unsigned QLO_NUM_CH_DEF = 4;
  localparam int unsigned QLO_ADDR_W = 4;
  localparam logic [QLO_ADDR_W-1:0] QLO_OFS_PHASE = 4'h0;
  localparam logic [QLO_ADDR_W-1:0] QLO_OFS_ENABLE = 4'h4;
  localparam logic [QLO_ADDR_W-1:0] QLO_OFS_STATUS = 4'h8;
  localparam logic [QLO_ADDR_W-1:0] QLO_OFS_ACTIVE = 4'hC;
  localparam logic [31:0] QLO_RESET_WORD = 32'h0000_0000;
  localparam logic [1:0] QLO_HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] QLO_HSIZE_WORD = 3'b010;
  localparam logic [1:0] QLO_QUAD_RESET = 2'b00;
  localparam int unsigned QLO_STAT_RUN_BIT = 0;
  localparam int unsigned QLO_STAT_I_BIT = 1;
  localparam int unsigned QLO_STAT_Q_BIT = 2;
  localparam int unsigned QLO_STAT_QUAD_LSB = 4;
  localparam int unsigned QLO_STAT_PEND_BIT = 8;
endpackage : qlo_pkg
